// >>> ddt_defs.svh
// Constants for the device-side command timing block.
// Assumes a single 20 MHz command clock shared with the controller logic.
// Operation
// - DLL-off read strobe window at latency sum minus one
// - Auto precharge held until row active time
// - Recovery starts write latency plus four; fixed chop two
// - Device accepts rounded-up cycle counts despite jitter
`ifndef DDT_DEFS_SVH
`define DDT_DEFS_SVH

`define DDT_CLK_PERIOD_PS   50000
`define DDT_STROBE_LESS     7'h01
`define DDT_WR_START_FULL   7'h04
`define DDT_WR_START_CHOP   7'h02
`define DDT_SYNC_W          23
`define DDT_POS_CMD         20
`define DDT_POS_BANK        17
`define DDT_POS_RD_LAT      12
`define DDT_POS_ADD_LAT     7
`define DDT_POS_WR_LAT      2
`define DDT_POS_DLL         1
`define DDT_POS_CHOP        0
`define DDT_SCHED_W         64
`define DDT_AGE_SAT         7'h7F

`endif

// >>> ddt_pkg.sv
// Types shared by the command timing block.
// Assumes commands arrive already decoded to a 3-bit code.
package ddt_pkg;

  typedef enum logic [2:0] {
    DDT_CMD_NOP  = 3'h0,
    DDT_CMD_ACT  = 3'h1,
    DDT_CMD_RD   = 3'h2,
    DDT_CMD_RD_AP = 3'h3,
    DDT_CMD_WR   = 3'h4,
    DDT_CMD_WRAP = 3'h5,
    DDT_CMD_PRE  = 3'h6,
    DDT_CMD_REF  = 3'h7
  } ddt_cmd_t;

  // Whole cycles covering a time, rounded up, never below one
  function automatic int ddt_ceil_div(input int num, input int den);
    int q;
    q = (num + den - 1) / den;
    return (q < 1) ? 1 : q;
  endfunction

endpackage

// >>> ddt_cmd_timing.sv
// Device-side command timing: DLL-off read strobe window, auto precharge
// hold-off and write recovery start. Assumes commands and mode settings
// arrive on pins from the controller and are synchronised here.
`timescale 1ns/100ps
`default_nettype none
`include "ddt_defs.svh"

module ddt_cmd_timing
  import ddt_pkg::*;
#(
  parameter int ROW_ACTIVE_MIN_PS = 35000  // Least row active time
) (
  input  wire logic       i_clk,              // Command clock
  input  wire logic       i_rst_b,            // Async reset, active low
  input  wire logic [2:0] i_cmd,              // Decoded command code
  input  wire logic [2:0] i_bank,             // Target bank
  input  wire logic [4:0] i_read_latency,     // Read latency, cycles
  input  wire logic [4:0] i_additive_latency, // Additive latency, cycles
  input  wire logic [4:0] i_write_latency,    // Write latency, cycles
  input  wire logic       i_dll_off,          // DLL disabled mode
  input  wire logic       i_chop_fixed,       // Chop four fixed by mode set
  output logic            o_strobe_window,    // DLL-off strobe window start
  output logic            o_wr_recovery_start,// Write recovery start edge
  output logic            o_precharge,        // Internal precharge pulse
  output logic [2:0]      o_precharge_bank    // Bank of internal precharge
);

  // Row active minimum rounded up; jitter never shortens it further
  localparam int RAS_CYC = ddt_ceil_div(ROW_ACTIVE_MIN_PS, `DDT_CLK_PERIOD_PS);
  localparam logic [7:0] RAS_CNT = 8'(RAS_CYC);
  // Checks see the age one edge late, so readiness shows one edge after
  localparam int         RAS_WAIT = RAS_CYC + 1;

  logic [`DDT_SYNC_W-1:0] sync_a;
  logic [`DDT_SYNC_W-1:0] sync_b;
  ddt_cmd_t               cmd;
  logic [2:0]             bank;
  logic [4:0]             rd_lat;
  logic [4:0]             add_lat;
  logic [4:0]             wr_lat;
  logic                   dll_off;
  logic                   chop_fixed;
  logic [`DDT_SCHED_W-1:0] rd_sched;
  logic [`DDT_SCHED_W-1:0] wr_sched;
  logic [6:0]             rd_dly;
  logic [6:0]             wr_dly;
  logic [7:0]             row_age [8];
  logic [7:0]             ap_pend;
  logic                   next_pre;
  logic [2:0]             next_pre_bank;
  logic                   is_read;
  logic                   is_write;
  logic                   is_ap;

  // Pins come from outside the clock domain: two flops before any use
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync_a <= '0;
      sync_b <= '0;
    end else begin
      sync_a <= {i_cmd, i_bank, i_read_latency, i_additive_latency,
                 i_write_latency, i_dll_off, i_chop_fixed};
      sync_b <= sync_a;
    end
  end

  // Field positions follow the order of the concatenation above
  assign cmd        = ddt_cmd_t'(sync_b[`DDT_POS_CMD +: 3]);
  assign bank       = sync_b[`DDT_POS_BANK +: 3];
  assign rd_lat     = sync_b[`DDT_POS_RD_LAT +: 5];
  assign add_lat    = sync_b[`DDT_POS_ADD_LAT +: 5];
  assign wr_lat     = sync_b[`DDT_POS_WR_LAT +: 5];
  assign dll_off    = sync_b[`DDT_POS_DLL];
  assign chop_fixed = sync_b[`DDT_POS_CHOP];
  assign is_read    = (cmd == DDT_CMD_RD) || (cmd == DDT_CMD_RD_AP);
  assign is_write   = (cmd == DDT_CMD_WR) || (cmd == DDT_CMD_WRAP);
  assign is_ap      = (cmd == DDT_CMD_RD_AP) || (cmd == DDT_CMD_WRAP);

  // Delays counted from the edge that registers the command
  assign rd_dly = 7'(rd_lat) + 7'(add_lat) - `DDT_STROBE_LESS;
  assign wr_dly = 7'(wr_lat) + (chop_fixed ? `DDT_WR_START_CHOP : `DDT_WR_START_FULL);

  // Read schedule: a shift line lets overlapping reads each get a slot
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_sched        <= '0;
      o_strobe_window <= 1'b0;
    end else begin
      o_strobe_window <= rd_sched[0];
      rd_sched        <= rd_sched >> 1;
      if (is_read && dll_off && rd_dly != 7'h00) begin
        rd_sched[6'(rd_dly - 7'h01)] <= 1'b1;
      end
    end
  end

  // Write recovery start edge, one slot per write
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_sched            <= '0;
      o_wr_recovery_start <= 1'b0;
    end else begin
      o_wr_recovery_start <= wr_sched[0];
      wr_sched            <= wr_sched >> 1;
      if (is_write) begin
        wr_sched[6'(wr_dly - 7'h01)] <= 1'b1;
      end
    end
  end

  // Row age per bank, saturating so a long-open row stays eligible
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int b = 0; b < 8; b++) row_age[b] <= '0;
    end else begin
      for (int b = 0; b < 8; b++) begin
        if (cmd == DDT_CMD_ACT && bank == 3'(b)) begin
          row_age[b] <= '0;
        end else if (row_age[b] < RAS_CNT) begin
          row_age[b] <= row_age[b] + 8'h01;
        end
      end
    end
  end

  // Lowest ready bank wins; one internal precharge per cycle
  always_comb begin
    next_pre      = 1'b0;
    next_pre_bank = 3'h0;
    for (int b = 7; b >= 0; b--) begin
      if (ap_pend[b] && row_age[b] >= RAS_CNT) begin
        next_pre      = 1'b1;
        next_pre_bank = 3'(b);
      end
    end
  end

  // Pending auto precharge: a new request outranks the issue clear
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ap_pend          <= '0;
      o_precharge      <= 1'b0;
      o_precharge_bank <= 3'h0;
    end else begin
      o_precharge      <= next_pre;
      o_precharge_bank <= next_pre_bank;
      for (int b = 0; b < 8; b++) begin
        if (is_ap && bank == 3'(b)) begin
          ap_pend[b] <= 1'b1;
        end else if (next_pre && next_pre_bank == 3'(b)) begin
          ap_pend[b] <= 1'b0;
        end
      end
    end
  end

  // Helper ages for the checks below; a newer command restarts them, so
  // overlapping commands only have their last one checked here
  logic [6:0] rd_age;
  logic [6:0] rd_seen;
  logic [6:0] wr_age;
  logic [6:0] wr_seen;
  logic [7:0] sel_age;

  assign sel_age = row_age[next_pre_bank];

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_age  <= `DDT_AGE_SAT;
      rd_seen <= '0;
      wr_age  <= `DDT_AGE_SAT;
      wr_seen <= '0;
    end else begin
      rd_age <= (rd_age == `DDT_AGE_SAT) ? rd_age : rd_age + 7'h01;
      wr_age <= (wr_age == `DDT_AGE_SAT) ? wr_age : wr_age + 7'h01;
      if (is_read && dll_off) begin
        rd_age  <= '0;
        rd_seen <= rd_dly;
      end
      if (is_write) begin
        wr_age  <= '0;
        wr_seen <= wr_dly;
      end
    end
  end

  sequence s_ap_request;
    is_ap;
  endsequence

  sequence s_issue;
    o_precharge;
  endsequence

  AST_STROBE_AT_LATENCY: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (rd_age == rd_seen && rd_seen != 7'h00) |-> o_strobe_window)
    else $error("Strobe window missing at latency sum minus one");

  AST_WR_RECOVERY_EDGE: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (wr_age == wr_seen && wr_seen != 7'h00) |-> o_wr_recovery_start)
    else $error("Write recovery start not at expected edge");

  AST_AP_HOLD_OFF: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    s_issue |-> $past(sel_age) >= RAS_CNT)
    else $error("Internal precharge before row active time");

  AST_AP_SERVED: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    s_ap_request |-> ##[1:40] s_issue)
    else $error("Auto precharge request never served");

  // Ready neither early nor late: the whole rounded count, then at once
  AST_RAS_ROUNDED: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    (cmd == DDT_CMD_ACT) |-> ##RAS_CYC (row_age[$past(bank, RAS_CYC)] < RAS_CNT)
      ##1 (row_age[$past(bank, RAS_WAIT)] >= RAS_CNT))
    else $error("Row age not ready after rounded count");

  AST_AP_BANK_PENDING: assert property (
    @(posedge i_clk) disable iff (!i_rst_b)
    s_issue |-> ($past(ap_pend) & (8'h01 << o_precharge_bank)) != 8'h00)
    else $error("Internal precharge for a bank with no pending request");

endmodule

`default_nettype wire

// >>> ddt_ctl_model.sv
// Controller model: drives commands and mode pins at the falling edge.
// Assumes the bench calls its tasks and shares the command clock.
`timescale 1ns/100ps
`default_nettype none
module ddt_ctl_model
  import ddt_pkg::*;
(
  input  wire logic  i_clk,     // Command clock
  output logic [2:0] o_cmd,     // Command code
  output logic [2:0] o_bank,    // Command bank
  output logic [4:0] o_rd_lat,  // Read latency
  output logic [4:0] o_add_lat, // Additive latency
  output logic [4:0] o_wr_lat,  // Write latency
  output logic       o_dll_off, // DLL disabled
  output logic       o_chop     // Chop four fixed
);
  // Minimum times rounded up to whole cycles, never below the cycle floor
  localparam int WR_GAP = 4;
  localparam int LOCK_GAP = 10;
  // Average refresh interval in cycles, a maximum so rounded down
  localparam int REF_CYC = 156;
  localparam int REF_MAX = 8;
  logic last_wr;
  logic hot;
  int   due;
  int   paid;
  int   ref_tick;

  // Idle pins from time zero
  initial begin
    {o_cmd, o_bank, o_rd_lat, o_add_lat, o_wr_lat, o_dll_off, o_chop, last_wr} = '0;
    hot = 1'b0;
    due = 0;
    paid = 0;
    ref_tick = 0;
  end

  // Refreshes owed: one per interval, twice as often when running hot
  always @(posedge i_clk) begin
    if (ref_tick + 1 >= (hot ? REF_CYC / 2 : REF_CYC)) begin
      ref_tick <= 0;
      due <= due + 1;
    end else begin
      ref_tick <= ref_tick + 1;
    end
  end

  // Latency change, then hold off long enough for the DLL to settle
  task automatic set_mode(input logic [4:0] rd_lat, add_lat, wr_lat, input logic dll, chop);
    @(negedge i_clk);
    o_cmd = DDT_CMD_NOP;
    o_rd_lat = rd_lat;
    o_add_lat = add_lat;
    o_wr_lat = wr_lat;
    o_dll_off = dll;
    o_chop = chop;
    last_wr = 1'b0;
    repeat (LOCK_GAP) @(negedge i_clk);
  endtask

  // One command for one cycle; a write is followed by recovery time
  task automatic issue(input ddt_cmd_t c, input logic [2:0] b);
    @(negedge i_clk);
    if (last_wr) begin
      o_cmd = DDT_CMD_NOP;
      repeat (WR_GAP) @(negedge i_clk);
    end
    // Postponement limit reached: refresh before anything else
    while (due - paid >= REF_MAX) begin
      o_cmd = DDT_CMD_REF;
      paid++;
      @(negedge i_clk);
      o_cmd = DDT_CMD_NOP;
      @(negedge i_clk);
    end
    o_cmd = c;
    o_bank = b;
    last_wr = (c == DDT_CMD_WR) || (c == DDT_CMD_WRAP);
  endtask

  // Quiet cycles pay back owed refreshes, each followed by a NOP
  task automatic idle(input int n);
    @(negedge i_clk);
    o_cmd = DDT_CMD_NOP;
    repeat (n) begin
      @(negedge i_clk);
      if (due > paid && o_cmd == DDT_CMD_NOP) begin
        o_cmd = DDT_CMD_REF;
        paid++;
      end else begin
        o_cmd = DDT_CMD_NOP;
      end
    end
  endtask
endmodule
`default_nettype wire

// >>> ddt_cmd_timing_tb.sv
// Bench for the command timing block: random latencies, scoreboard queues.
// Assumes the controller model drives all command and mode pins.
`timescale 1ns/100ps
`default_nettype none
module ddt_cmd_timing_tb;
  import ddt_pkg::*;
  localparam int RAS_PS = 180000;
  localparam int RAS_CYC = (RAS_PS + 49999) / 50000;
  logic clk, rst_b, o_str, o_wrs, o_pre;
  logic [2:0] cmd, bank, o_pb, b;
  logic [4:0] rd_lat, add_lat, wr_lat;
  logic dll, chop;
  int cyc, fails, cmp_count, seed, ca, c, k;
  int q_str[$], q_wr[$], q_pre[$];
  logic [2:0] q_bank[$];

  ddt_ctl_model i_ctl (.i_clk(clk), .o_cmd(cmd), .o_bank(bank), .o_rd_lat(rd_lat),
    .o_add_lat(add_lat), .o_wr_lat(wr_lat), .o_dll_off(dll), .o_chop(chop));
  ddt_cmd_timing #(.ROW_ACTIVE_MIN_PS(RAS_PS)) i_dut (.i_clk(clk), .i_rst_b(rst_b),
    .i_cmd(cmd), .i_bank(bank), .i_read_latency(rd_lat), .i_additive_latency(add_lat),
    .i_write_latency(wr_lat), .i_dll_off(dll), .i_chop_fixed(chop),
    .o_strobe_window(o_str), .o_wr_recovery_start(o_wrs), .o_precharge(o_pre),
    .o_precharge_bank(o_pb));

  initial clk = 1'b0;
  always #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  // Expected pulse edge for a read or write sampled at edge at
  task automatic note(input int at, input logic rd);
    if (rd && dll) q_str.push_back(at + 1 + rd_lat + add_lat);
    if (!rd) q_wr.push_back(at + 2 + wr_lat + (chop ? 2 : 4));
  endtask

  task automatic close_out();
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Each pulse takes the oldest note; a pulse with no note is a mismatch
  always @(negedge clk) begin
    if (o_str !== 1'b0) chk(cyc, q_str.size() ? q_str.pop_front() : -1);
    if (o_wrs !== 1'b0) chk(cyc, q_wr.size() ? q_wr.pop_front() : -1);
    if (o_pre !== 1'b0) begin
      chk(cyc, q_pre.size() ? q_pre.pop_front() : -1);
      chk({29'h0, o_pb}, {29'h0, q_bank.size() ? q_bank.pop_front() : 3'h0});
    end
  end

  // Cut a hang short well past the expected run length
  initial begin
    #(3000 * 50);
    fails++;
    close_out();
  end

  initial begin
    seed = 67046;
    {cyc, fails, cmp_count} = '0;
    rst_b = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    for (k = 0; k < 8; k++) begin
      b = 3'($random(seed));
      i_ctl.set_mode(5'h05 + 5'($unsigned($random(seed)) % 7),
        5'($unsigned($random(seed)) % 4), 5'h05 + 5'($unsigned($random(seed)) % 4),
        k[0], k[1]);
      // Activate then auto precharge at once, so the hold-off must act
      i_ctl.issue(DDT_CMD_ACT, b);
      ca = cyc + 1;
      i_ctl.issue(k[2] ? DDT_CMD_RD_AP : DDT_CMD_WRAP, b);
      c = cyc + 1;
      q_pre.push_back((c + 3 > ca + 3 + RAS_CYC) ? c + 3 : ca + 3 + RAS_CYC);
      q_bank.push_back(b);
      // Every write, and every read with the DLL off, the auto precharge one too, gives its own pulse
      note(c, k[2]);
      repeat (2) begin
        i_ctl.issue(k[2] ? DDT_CMD_RD : DDT_CMD_WR, b + 3'h1);
        c = cyc + 1;
        note(c, k[2]);
      end
      i_ctl.idle(40);
    end
    chk(q_str.size() + q_wr.size() + q_pre.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire
